// ### rtl/icd_pkg.sv
/*
 Package of the impedance channel configuration decode: register offsets,
 field positions, reset values and decode constants.
 Assumes nothing of its surroundings; every user names items package::name.
*/
package icd_pkg;

   // ***********************************************************
   // Register map
   // ***********************************************************
   localparam logic [7:0]  ADDR_CHANNEL_SETTINGS = 8'h18;   // Channel settings word
   localparam logic [7:0]  ADDR_SELFTEST         = 8'h1C;   // Self-test selection word
   localparam logic [7:0]  ADDR_CONTROL          = 8'h20;   // Command word
   localparam logic [7:0]  ADDR_STATUS           = 8'h24;   // Decoded state word

   // ***********************************************************
   // Channel settings fields
   // ***********************************************************
   localparam int          POS_RATE     = 23;   // Sample rate select
   localparam int          POS_AHPF     = 20;   // Analog high-pass, 3 bits
   localparam int          POS_EXTBIAS  = 19;   // External bias resistor
   localparam int          POS_LOWNOISE = 18;   // Amplifier power mode
   localparam int          POS_GAIN     = 16;   // Gain, 2 bits
   localparam int          POS_DHPF     = 14;   // Digital high-pass, 2 bits
   localparam int          POS_DLPF     = 12;   // Digital low-pass, 2 bits
   localparam int          SETTINGS_W   = 24;   // Register width

   // Reset values
   localparam logic [23:0] RESET_SETTINGS = 24'h201000;   // Rate 0, AHPF 010, DLPF 01

   // ***********************************************************
   // Self-test selection fields
   // ***********************************************************
   localparam int          POS_RNOM     = 8;   // Nominal resistance, 3 bits
   localparam int          POS_RMOD     = 4;   // Modulation, 3 bits
   localparam logic [2:0]  RESET_RNOM   = 3'h0;
   localparam logic [2:0]  RESET_RMOD   = 3'h4;   // All modulation switches open

   // ***********************************************************
   // Decode constants
   // ***********************************************************
   localparam logic [1:0]  DLPF_4HZ     = 2'h1;   // Fallback low-pass
   localparam logic [1:0]  DLPF_16HZ    = 2'h3;   // Needs the higher rate
   localparam logic [1:0]  DHPF_BYPASS  = 2'h0;
   localparam logic [2:0]  AHPF_LAST    = 3'h5;   // Codes above bypass the filter
   localparam logic [2:0]  RNOM_SWITCH  = 3'h3;   // Extra nominal switches from here
   localparam logic [2:0]  RMOD_DEPTH2  = 3'h2;   // Shallowest depth
   localparam int          RESYNC_CYCLES = 4;     // Length of resync pulse

   // Divider from the nominal code to 5000 ohm / n
   localparam logic [3:0]  RNOM_DIVIDER [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};

endpackage

// ### rtl/icd_cfg_if.sv
/*
 Interface carrying the stored settings from the register bank into the
 decoder and the decoded state back.
 Assumes one clock domain; used only between this block's own modules.
*/
`timescale 1ns/10ps
interface icd_cfg_if;
   logic [23:0] settings;        // Stored channel settings as written
   logic [2:0]  nominal_sel;     // Stored nominal resistance code
   logic [2:0]  modulation_sel;  // Stored modulation code
   logic [1:0]  effective_dlpf;  // Low-pass in use
   logic [12:0] nominal_ohms;    // Nominal resistance applied
   logic [1:0]  mod_depth;       // 0 none, 1..3 deepest to shallowest
   logic        switches_on;     // Extra nominal switches engaged
   logic        modulated;       // Modulation in effect

   modport bank (output settings, nominal_sel, modulation_sel,
                 input effective_dlpf, nominal_ohms, mod_depth, switches_on, modulated);
   modport dec  (input settings, nominal_sel, modulation_sel,
                 output effective_dlpf, nominal_ohms, mod_depth, switches_on, modulated);
endinterface

// ### rtl/icd_decode.sv
/*
 Combinational decoder of the self-test resistance and low-pass fallback.
 Assumes stored settings arrive over icd_cfg_if; the caller drives its
 ports from the outputs directly, unregistered.
*/
`timescale 1ns/10ps
module icd_decode
(
   // Settings in, decode out
   icd_cfg_if.dec cfg
);

   // ***********************************************************
   // Decoding
   // ***********************************************************

   // Nominal resistance from the code, 5000/n; code 2 rounds up
   function automatic logic [12:0] nominal_of(input logic [2:0] code);
      logic [12:0] ohms;
      ohms = 13'(16'h1388 / {12'h000, icd_pkg::RNOM_DIVIDER[code]});
      if (code == 3'h2)
      begin
         ohms = 13'h0683;   // 1667, rounded up
      end
      return ohms;
   endfunction

   // Nominal and modulation decode
   always_comb
   begin
      cfg.nominal_ohms = nominal_of(cfg.nominal_sel);   // R1 R2
      cfg.switches_on  = cfg.nominal_sel >= icd_pkg::RNOM_SWITCH;   // R2
      cfg.mod_depth    = 2'h0;
      if (!cfg.modulation_sel[2])
      begin
         // Code 010 with extra switches leaves the channel unmodulated
         if (cfg.switches_on && cfg.modulation_sel == icd_pkg::RMOD_DEPTH2)
         begin
            cfg.mod_depth = 2'h0;   // R3
         end
         else if (cfg.modulation_sel <= icd_pkg::RMOD_DEPTH2)
         begin
            cfg.mod_depth = 2'(cfg.modulation_sel[1:0] + 2'h1);   // R1 R2
         end
      end
      cfg.modulated = cfg.mod_depth != 2'h0;   // R1 R2
   end

   // Low-pass fallback when 16 Hz is asked at the lower rate
   always_comb
   begin
      cfg.effective_dlpf = cfg.settings[icd_pkg::POS_DLPF +: 2];   // R17
      if (cfg.settings[icd_pkg::POS_RATE] && cfg.effective_dlpf == icd_pkg::DLPF_16HZ)
      begin
         cfg.effective_dlpf = icd_pkg::DLPF_4HZ;   // R18
      end
   end

endmodule

// ### rtl/icd_resync.sv
/*
 Resynchronize pulse generator: stretches one command into a fixed pulse.
 Assumes a single clock and active-low asynchronous reset.
*/
`timescale 1ns/10ps
module icd_resync
(
   // Clock and reset
   input  wire  logic pclk,
   input  wire  logic presetn,
   input  wire  logic clk_en,
   // Command and pulse
   input  wire  logic start,
   output logic       pulse
);

   logic [2:0] count;   // Remaining pulse cycles

   // Restart on every command so a late one still gets a full pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count <= 3'h0;
      end
      else if (clk_en)
      begin
         if (start)
         begin
            count <= 3'(icd_pkg::RESYNC_CYCLES);   // R7
         end
         else if (count != 3'h0)
         begin
            count <= count - 3'h1;
         end
      end
   end

   assign pulse = count != 3'h0;

endmodule

// ### rtl/icd_top.sv
/*
 Impedance channel configuration register bank with APB slave.
 Assumes an APB master on pclk and a master clock select from the device.
*/
// Contract
// R1 - Low nominal codes: 5000/2500/1667, three depths
// R2 - High codes: extra switches, two depths
// R3 - High code with modulation 010 unmodulated
// R4 - Software avoids modulation code 011; reset 100
// R5 - Settings register at 0x18 read/write
// R6 - Writes may disturb sample timing
// R7 - Resynchronize command restores sampling sync
// R8 - Clock 00: 64 or 32 sps
// R9 - Clock 01: 62.50 or 31.25 sps
// R10 - Clock 10: 50 or 25 sps
// R11 - Clock 11: 49.95 or 24.98 sps
// R12 - Analog high-pass bits 22:20, reset 010
// R13 - Bit 19 selects external bias
// R14 - Bit 18 selects low-noise amplifier
// R15 - Gain bits 17:16: 10 to 80
// R16 - Digital high-pass bits 15:14
// R17 - Low-pass bits 13:12, 16 Hz limited
// R18 - Unsupported low-pass runs 4 Hz, reads effective
`timescale 1ns/10ps
module icd_top
(
   // APB
   input  wire  logic        pclk,
   input  wire  logic        presetn,
   input  wire  logic        clk_en,
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [7:0]  paddr,
   input  wire  logic [31:0] pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // Device context
   input  wire  logic [1:0]  master_clock_freq_sel,
   // Channel controls
   output logic              sample_rate_sel,
   output logic [15:0]       sample_rate_centi_sps,
   output logic [2:0]        analog_highpass_sel,
   output logic              analog_highpass_bypass,
   output logic              external_bias_resistor_en,
   output logic              low_noise_amp_mode,
   output logic [6:0]        gain_vv,
   output logic [1:0]        digital_highpass_sel,
   output logic [1:0]        digital_lowpass_sel,
   output logic              settings_changed,
   output logic              resynchronize_command,
   // Self-test controls
   output logic [12:0]       nominal_ohms,
   output logic [1:0]        modulation_depth,
   output logic              nominal_resistor_switches,
   output logic              modulation_switches
);

   // ***********************************************************
   // Storage
   // ***********************************************************
   icd_cfg_if  cfg ();            // Bank to decoder
   logic [23:0] settings;         // Channel settings as written
   logic [2:0]  nominal_sel;      // Self-test nominal code
   logic [2:0]  modulation_sel;   // Self-test modulation code
   logic        resync_start;     // Command pulse
   logic        wr_en;            // Write taken this edge
   logic [31:0] next_prdata;      // Read mux

   assign cfg.settings       = settings;
   assign cfg.nominal_sel    = nominal_sel;
   assign cfg.modulation_sel = modulation_sel;

   icd_decode icd_decode_inst
   (
      .cfg (cfg)
   );

   icd_resync icd_resync_inst
   (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .start   (resync_start),
      .pulse   (resynchronize_command)
   );

   // Zero wait state slave, errors on unmapped address
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !(paddr == icd_pkg::ADDR_CHANNEL_SETTINGS ||
                    paddr == icd_pkg::ADDR_SELFTEST || paddr == icd_pkg::ADDR_CONTROL ||
                    paddr == icd_pkg::ADDR_STATUS);
   assign wr_en   = clk_en && psel && penable && pwrite;

   // ***********************************************************
   // Register writes
   // ***********************************************************

   // Channel settings, all 24 bits stored as written
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         settings <= icd_pkg::RESET_SETTINGS;   // R12 R8
      end
      else if (wr_en && paddr == icd_pkg::ADDR_CHANNEL_SETTINGS)
      begin
         settings <= pwdata[23:0];   // R5 R18
      end
   end

   // Self-test selection; reset opens modulation switches
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         nominal_sel    <= icd_pkg::RESET_RNOM;
         modulation_sel <= icd_pkg::RESET_RMOD;   // R4
      end
      else if (wr_en && paddr == icd_pkg::ADDR_SELFTEST)
      begin
         nominal_sel    <= pwdata[icd_pkg::POS_RNOM +: 3];
         modulation_sel <= pwdata[icd_pkg::POS_RMOD +: 3];
      end
   end

   // Command bit 0 of control word starts resync
   assign resync_start = wr_en && paddr == icd_pkg::ADDR_CONTROL && pwdata[0];   // R7

   // Change flag: one cycle after any settings write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         settings_changed <= 1'b0;
      end
      else if (clk_en)
      begin
         settings_changed <= wr_en && paddr == icd_pkg::ADDR_CHANNEL_SETTINGS;   // R6
      end
   end

   // ***********************************************************
   // Read path
   // ***********************************************************

   // Read mux; settings return effective low-pass
   always_comb
   begin
      next_prdata = 32'h00000000;
      unique case (paddr)
         icd_pkg::ADDR_CHANNEL_SETTINGS:
         begin
            next_prdata[23:0]  = settings;   // R5
            next_prdata[13:12] = cfg.effective_dlpf;   // R18
         end
         icd_pkg::ADDR_SELFTEST:
         begin
            next_prdata[10:8] = nominal_sel;
            next_prdata[6:4]  = modulation_sel;
         end
         icd_pkg::ADDR_STATUS:
         begin
            next_prdata[12:0]  = cfg.nominal_ohms;
            next_prdata[17:16] = cfg.mod_depth;
            next_prdata[18]    = cfg.switches_on;
            next_prdata[19]    = resynchronize_command;
         end
         default:
         begin
            next_prdata = 32'h00000000;
         end
      endcase
   end

   // Read data from a flop, loaded in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
      end
      else if (clk_en && psel && !penable)
      begin
         prdata <= next_prdata;
      end
   end

   // ***********************************************************
   // Decoded controls
   // ***********************************************************

   // Rate in hundredths of sps from master clock and rate bit
   always_comb
   begin
      unique case ({master_clock_freq_sel, settings[icd_pkg::POS_RATE]})
         3'h0: sample_rate_centi_sps = 16'h1900;   // R8 64
         3'h1: sample_rate_centi_sps = 16'h0C80;   // R8 32
         3'h2: sample_rate_centi_sps = 16'h186A;   // R9 62.50
         3'h3: sample_rate_centi_sps = 16'h0C35;   // R9 31.25
         3'h4: sample_rate_centi_sps = 16'h1388;   // R10 50
         3'h5: sample_rate_centi_sps = 16'h09C4;   // R10 25
         3'h6: sample_rate_centi_sps = 16'h1383;   // R11 49.95
         3'h7: sample_rate_centi_sps = 16'h09C2;   // R11 24.98
      endcase
   end

   assign sample_rate_sel           = settings[icd_pkg::POS_RATE];   // R8
   assign analog_highpass_sel       = settings[icd_pkg::POS_AHPF +: 3];   // R12
   assign analog_highpass_bypass    = analog_highpass_sel > icd_pkg::AHPF_LAST;   // R12
   assign external_bias_resistor_en = settings[icd_pkg::POS_EXTBIAS];   // R13
   assign low_noise_amp_mode        = settings[icd_pkg::POS_LOWNOISE];   // R14
   assign gain_vv                   = 7'(7'h0A << settings[icd_pkg::POS_GAIN +: 2]);   // R15
   assign digital_highpass_sel      = settings[icd_pkg::POS_DHPF +: 2];   // R16
   assign digital_lowpass_sel       = cfg.effective_dlpf;   // R17 R18
   assign nominal_ohms              = cfg.nominal_ohms;   // R1 R2
   assign modulation_depth          = cfg.mod_depth;   // R3
   assign nominal_resistor_switches = cfg.switches_on;   // R2
   assign modulation_switches       = cfg.modulated;   // R1

endmodule

// ### verification/icd_checker.sv
/*
 Assertions on the impedance channel configuration decode top ports.
 Assumes one pclk domain and presetn asynchronous, active low.
*/
`timescale 1ns/10ps
module icd_checker
(
   // Clock, reset and bus
   input logic        pclk,
   input logic        presetn,
   input logic        clk_en,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] pwdata,
   input logic        pslverr,
   // Channel and self-test outputs
   input logic [1:0]  master_clock_freq_sel,
   input logic        sample_rate_sel,
   input logic [15:0] sample_rate_centi_sps,
   input logic [2:0]  analog_highpass_sel,
   input logic        analog_highpass_bypass,
   input logic [1:0]  digital_lowpass_sel,
   input logic        settings_changed,
   input logic        resynchronize_command,
   input logic [12:0] nominal_ohms,
   input logic [1:0]  modulation_depth,
   input logic        nominal_resistor_switches,
   input logic        modulation_switches
);
   // ***************************************************
   // Helpers
   // ***************************************************
   // Rate in centi-sps, indexed by {clock select, rate bit}
   localparam logic [15:0] RATE [8] = '{16'h1900, 16'h0C80, 16'h186A, 16'h0C35,
                                        16'h1388, 16'h09C4, 16'h1383, 16'h09C2};
   wire acc    = psel && penable;                    // Access phase
   wire wr_set = clk_en && acc && pwrite && paddr == 8'h18;   // Settings write taken
   wire mapped = paddr inside {8'h18, 8'h1C, 8'h20, 8'h24};

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ***************************************************
   // Assertions
   // ***************************************************
   a_rate_table: assert property
      (sample_rate_centi_sps == RATE[{master_clock_freq_sel, sample_rate_sel}]) else $error("rate decode wrong");
   a_ahpf_bypass: assert property
      (analog_highpass_bypass == (analog_highpass_sel >= 3'h6)) else $error("high-pass bypass wrong");
   a_lowpass_limit: assert property
      (sample_rate_sel |-> digital_lowpass_sel != 2'h3) else $error("16 Hz low-pass at slow rate");
   a_nominal_switch: assert property
      (nominal_resistor_switches == (nominal_ohms <= 13'h04E2)) else $error("nominal switches wrong");
   a_high_depth: assert property
      (nominal_resistor_switches |-> modulation_depth != 2'h3) else $error("depth not allowed");
   a_mod_switch: assert property
      (modulation_switches == (modulation_depth != 2'h0)) else $error("modulation switches wrong");
   a_write_pulse: assert property
      ($past(clk_en) |-> settings_changed == $past(wr_set)) else $error("settings change pulse wrong");
   a_resync_len: assert property
      (clk_en && acc && pwrite && paddr == 8'h20 && pwdata[0] |=> resynchronize_command [*4])
      else $error("resync short");
   a_unmapped_err: assert property
      (acc |-> pslverr == !mapped) else $error("error response wrong");
   a_reset_selftest: assert property
      ($rose(presetn) |-> nominal_ohms == 13'h1388 && modulation_depth == 2'h0) else $error("self-test reset");
endmodule

bind icd_top icd_checker icd_checker_inst
(
   .pclk (pclk), .presetn (presetn), .clk_en (clk_en), .psel (psel), .penable (penable),
   .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .pslverr (pslverr),
   .master_clock_freq_sel (master_clock_freq_sel), .sample_rate_sel (sample_rate_sel),
   .sample_rate_centi_sps (sample_rate_centi_sps), .analog_highpass_sel (analog_highpass_sel),
   .analog_highpass_bypass (analog_highpass_bypass), .digital_lowpass_sel (digital_lowpass_sel),
   .settings_changed (settings_changed), .resynchronize_command (resynchronize_command),
   .nominal_ohms (nominal_ohms), .modulation_depth (modulation_depth),
   .nominal_resistor_switches (nominal_resistor_switches), .modulation_switches (modulation_switches)
);

// ### verification/impedance_channel_config_decode_test.sv
/*
 Self-checking bench of the impedance channel configuration decode.
 Assumes icd_top and icd_checker are compiled first; bench is APB master.
*/
`timescale 1ns/10ps
module impedance_channel_config_decode_test;
   // ***************************************************
   // Signals and tables
   // ***************************************************
   logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;   // Clock, reset, run
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;  // Bus controls
   logic [7:0]  paddr = 8'h00;                                 // Byte address
   logic [31:0] pwdata = 32'h0, prdata;                        // Bus data
   logic        pready, pslverr;                               // Slave answer
   logic [1:0]  master_clock_freq_sel = 2'h0;                  // Device clock choice
   logic        sample_rate_sel, analog_highpass_bypass, external_bias_resistor_en;
   logic        low_noise_amp_mode, settings_changed, resynchronize_command;
   logic        nominal_resistor_switches, modulation_switches;
   logic [15:0] sample_rate_centi_sps;
   logic [2:0]  analog_highpass_sel;
   logic [6:0]  gain_vv;
   logic [1:0]  digital_highpass_sel, digital_lowpass_sel, modulation_depth;
   logic [12:0] nominal_ohms;
   logic [31:0] q, v;          // Read data, written word
   logic        e;             // Error response
   int          miscompares = 0, n_tests = 0, n_sync = 0;
   localparam logic [15:0] RATE [8] = '{16'h1900, 16'h0C80, 16'h186A, 16'h0C35,
                                        16'h1388, 16'h09C4, 16'h1383, 16'h09C2};
   localparam logic [12:0] OHMS [8] = '{13'h1388, 13'h09C4, 13'h0683, 13'h04E2,
                                        13'h03E8, 13'h0341, 13'h02CA, 13'h0271};

   icd_top icd_top_inst
   (
      .pclk (pclk), .presetn (presetn), .clk_en (clk_en), .psel (psel), .penable (penable),
      .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata), .pready (pready),
      .pslverr (pslverr), .master_clock_freq_sel (master_clock_freq_sel), .sample_rate_sel (sample_rate_sel),
      .sample_rate_centi_sps (sample_rate_centi_sps), .analog_highpass_sel (analog_highpass_sel),
      .analog_highpass_bypass (analog_highpass_bypass), .external_bias_resistor_en (external_bias_resistor_en),
      .low_noise_amp_mode (low_noise_amp_mode), .gain_vv (gain_vv), .digital_highpass_sel (digital_highpass_sel),
      .digital_lowpass_sel (digital_lowpass_sel), .settings_changed (settings_changed),
      .resynchronize_command (resynchronize_command), .nominal_ohms (nominal_ohms),
      .modulation_depth (modulation_depth), .nominal_resistor_switches (nominal_resistor_switches),
      .modulation_switches (modulation_switches)
   );

   // Free-running bus clock, 8 ns
   always #4 pclk = ~pclk;

   // Count resync cycles seen high
   always @(posedge pclk)
      if (resynchronize_command === 1'b1)
         n_sync++;

   // ***************************************************
   // Bus and compare tasks
   // ***************************************************
   // Setup, then access held until pready; idle cycle after so strobes never double up
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic re);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rq = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d, q, e); endtask
   task automatic rd(input logic [7:0] a); apb(1'b0, a, 32'h0, q, e); endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test;
      if (miscompares == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_reset;
      rd(8'h18);
      chk("settings", 32'h0020_1000, q);
      rd(8'h1C);
      chk("selftest", 32'h0000_0040, q);
      chk("ohms", 32'h1388, 32'(nominal_ohms));
      chk("depth", 32'h0, 32'(modulation_depth));
   endtask

   // Every clock select with both rate bits
   task automatic t_rate;
      for (int i = 0; i < 8; i++)
      begin
         master_clock_freq_sel <= i[2:1];
         wr(8'h18, {8'h00, i[0], 23'h20_1000});
         chk("rate", 32'(RATE[i]), 32'(sample_rate_centi_sps));
         chk("rate bit", 32'(i[0]), 32'(sample_rate_sel));
      end
   endtask

   // Every high-pass code, gain and mode, with read-back
   task automatic t_fields;
      for (int i = 0; i < 8; i++)
      begin
         v = {8'h00, 1'b0, i[2:0], i[0], i[1], i[1:0], i[1:0], i[1:0], 12'h000};
         wr(8'h18, v);
         rd(8'h18);
         chk("readback", v, q);
         chk("ahpf", 32'(i[2:0]), 32'(analog_highpass_sel));
         chk("bypass", 32'(i >= 6), 32'(analog_highpass_bypass));
         chk("ext bias", 32'(i[0]), 32'(external_bias_resistor_en));
         chk("low noise", 32'(i[1]), 32'(low_noise_amp_mode));
         chk("gain", 32'(7'h0A << i[1:0]), 32'(gain_vv));
         chk("dhpf", 32'(i[1:0]), 32'(digital_highpass_sel));
         chk("dlpf", 32'(i[1:0]), 32'(digital_lowpass_sel));
      end
   endtask

   // 16 Hz at the slow rate falls back to 4 Hz
   task automatic t_lowpass;
      wr(8'h18, 32'h0080_3000);
      rd(8'h18);
      chk("dlpf read", 32'h0080_1000, q);
      chk("dlpf used", 32'h1, 32'(digital_lowpass_sel));
      wr(8'h18, 32'h0000_3000);
      rd(8'h18);
      chk("dlpf fast", 32'h0000_3000, q);
   endtask

   // Unmapped place refused, settings untouched
   task automatic t_unmapped;
      apb(1'b1, 8'h28, 32'hFFFF_FFFF, q, e);
      chk("wr err", 32'h1, 32'(e));
      rd(8'h28);
      chk("rd err", 32'h1, 32'(e));
      chk("rd data", 32'h0, q);
      rd(8'h18);
      chk("ok err", 32'h0, 32'(e));
      chk("kept", 32'h0000_3000, q);
   endtask

   // Clock enable low freezes state, so the write is dropped
   task automatic t_freeze;
      clk_en <= 1'b0;
      wr(8'h18, 32'h0000_2000);
      clk_en <= 1'b1;
      rd(8'h18);
      chk("frozen", 32'h0000_3000, q);
   endtask

   // Every nominal code against every legal modulation code
   task automatic t_selftest;
      int d;
      for (int n = 0; n < 8; n++)
         for (int m = 0; m < 8; m++)
         begin
            if (m == 3)
               continue;
            wr(8'h1C, {20'h0, 1'b0, n[2:0], 1'b0, m[2:0], 4'h0});
            d = (m > 2 || (n > 2 && m == 2)) ? 0 : m + 1;
            chk("ohms", 32'(OHMS[n]), 32'(nominal_ohms));
            chk("depth", 32'(d), 32'(modulation_depth));
            chk("switches", 32'(n > 2), 32'(nominal_resistor_switches));
            chk("mod on", 32'(d != 0), 32'(modulation_switches));
         end
   endtask

   task automatic t_resync;
      int c;
      c = n_sync;
      wr(8'h20, 32'h1);
      rd(8'h24);
      // Last self-test code 7/7: 625 ohm, switches in, busy while pulse runs
      chk("status", 32'h000C_0271, q);
      repeat (10) @(posedge pclk);
      chk("resync len", 32'h4, 32'(n_sync - c));
   endtask

   // Main sequence: reset held 10 cycles, then scenarios
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_rate;
      t_fields;
      t_lowpass;
      t_unmapped;
      t_freeze;
      t_selftest;
      t_resync;
      stop_test;
   end

   // Watchdog well beyond the expected run of about 300 cycles
   initial
   begin
      repeat (5000) @(posedge pclk);
      miscompares++;
      stop_test;
   end
endmodule
